// [msc_comm.sv]
// station, line config, timeout watchdog, reply delay and frequency scaling
`timescale 1ns/1ps
`include "msc_consts.svh"

// Contract
// - station address 0..247 held, reset 1, and address 0 means broadcast.
// - low config digit picks 9600, 19200 or 38400 bit/s for both ends.
// - tens config digit picks no, even or odd parity for both ends.
// - hundreds digit 0 replies, 1 replies to own address only, 2 never.
// - with policy 3 a broadcast coast-to-stop command is ignored.
// - no valid frame within the 0.1..100.0 s interval flags a failure.
// - an interval of zero turns the timeout supervision off.
// - reply starts after a 0..200 ms turnaround delay, default 5 ms.
// - a delay shorter than the processing time uses the processing time.
// - a received frequency is scaled by a 0.01..10.00 linkage ratio.
module msc_comm #(
  parameter int CYC_PER_MS = `MSC_CYC_PER_MS,
  parameter int MS_PER_TENTH = `MSC_MS_PER_TENTH,
  parameter int PROC_CYC = 1000
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic par_wr,
  input wire logic par_rd,
  input wire logic [7:0] par_idx,
  input wire logic [15:0] par_wdata,
  output logic [15:0] par_rdata,
  output logic par_ack,
  output logic par_err,
  input msc_pkg::msc_frame_t frm,
  input wire logic tx_done,
  output logic bit_tick,
  output logic [1:0] baud_sel,
  output logic [1:0] parity_sel,
  output logic frame_hit,
  output logic reply_go,
  output logic reply_busy,
  output logic coast_cmd,
  output logic freq_valid,
  output logic [15:0] freq_out,
  output logic comm_fail
);

  // ---------------------------------------------------------------
  // parameter store
  // ---------------------------------------------------------------
  logic [15:0] station_r, station_nxt;
  logic [15:0] config_r, config_nxt;
  logic [15:0] timeout_r, timeout_nxt;
  logic [15:0] delay_r, delay_nxt;
  logic [15:0] ratio_r, ratio_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic ack_r, ack_nxt;
  logic err_r, err_nxt;
  logic cfg_ok;
  logic tmo_written;

  // every config digit must be in range, else the whole write is refused
  assign cfg_ok = (par_wdata[`MSC_CFG_BAUD] <= `MSC_MAX_BAUD) &&
                  (par_wdata[`MSC_CFG_PAR] <= `MSC_MAX_PAR) &&
                  (par_wdata[`MSC_CFG_POL] <= `MSC_MAX_POL) &&
                  (par_wdata[`MSC_CFG_RSV] == 4'h0);
  assign tmo_written = par_wr && !err_nxt &&
                       (par_idx == `MSC_IDX_TIMEOUT);

  always_comb begin
    station_nxt = station_r;
    config_nxt = config_r;
    timeout_nxt = timeout_r;
    delay_nxt = delay_r;
    ratio_nxt = ratio_r;
    rdata_nxt = rdata_r;
    ack_nxt = par_wr || par_rd;
    err_nxt = 1'b0;
    if (par_wr) begin
      unique case (par_idx)
        `MSC_IDX_STATION: begin
          if (par_wdata <= `MSC_MAX_STATION) station_nxt = par_wdata;
          else err_nxt = 1'b1;
        end
        `MSC_IDX_CONFIG: begin
          if (cfg_ok) config_nxt = par_wdata;
          else err_nxt = 1'b1;
        end
        `MSC_IDX_TIMEOUT: begin
          if (par_wdata <= `MSC_MAX_TIMEOUT) timeout_nxt = par_wdata;
          else err_nxt = 1'b1;
        end
        `MSC_IDX_DELAY: begin
          if (par_wdata <= `MSC_MAX_DELAY) delay_nxt = par_wdata;
          else err_nxt = 1'b1;
        end
        `MSC_IDX_RATIO: begin
          if (par_wdata >= `MSC_MIN_RATIO && par_wdata <= `MSC_MAX_RATIO) begin
            ratio_nxt = par_wdata;
          end else begin
            err_nxt = 1'b1;
          end
        end
        `MSC_IDX_SPARE: err_nxt = (par_wdata != 16'h0000);
        default: err_nxt = 1'b1;
      endcase
    end else if (par_rd) begin
      unique case (par_idx)
        `MSC_IDX_STATION: rdata_nxt = station_r;
        `MSC_IDX_CONFIG: rdata_nxt = config_r;
        `MSC_IDX_TIMEOUT: rdata_nxt = timeout_r;
        `MSC_IDX_DELAY: rdata_nxt = delay_r;
        `MSC_IDX_RATIO: rdata_nxt = ratio_r;
        `MSC_IDX_SPARE: rdata_nxt = 16'h0000;
        default: begin
          rdata_nxt = 16'h0000;
          err_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      station_r <= `MSC_RST_STATION;
      config_r <= `MSC_RST_CONFIG;
      timeout_r <= `MSC_RST_TIMEOUT;
      delay_r <= `MSC_RST_DELAY;
      ratio_r <= `MSC_RST_RATIO;
      rdata_r <= 16'h0000;
      ack_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      station_r <= station_nxt;
      config_r <= config_nxt;
      timeout_r <= timeout_nxt;
      delay_r <= delay_nxt;
      ratio_r <= ratio_nxt;
      rdata_r <= rdata_nxt;
      ack_r <= ack_nxt;
      err_r <= err_nxt;
    end
  end

  // ---------------------------------------------------------------
  // line rate divider
  // ---------------------------------------------------------------
  logic [12:0] bit_cnt_r, bit_cnt_nxt;
  logic [12:0] bit_div;
  logic tick_r, tick_nxt;

  always_comb begin
    unique case (config_r[`MSC_CFG_BAUD])
      4'h1: bit_div = 13'(`MSC_BIT_CYC_19200);
      4'h2: bit_div = 13'(`MSC_BIT_CYC_38400);
      default: bit_div = 13'(`MSC_BIT_CYC_9600);
    endcase
    tick_nxt = 1'b0;
    bit_cnt_nxt = bit_cnt_r + 13'h0001;
    if (bit_cnt_r >= bit_div - 13'h0001) begin
      bit_cnt_nxt = 13'h0000;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bit_cnt_r <= 13'h0000;
      tick_r <= 1'b0;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  // ---------------------------------------------------------------
  // millisecond and tenth-second time base
  // ---------------------------------------------------------------
  logic [31:0] ms_cnt_r, ms_cnt_nxt;
  logic [7:0] tenth_cnt_r, tenth_cnt_nxt;
  logic ms_en, tenth_en;

  assign ms_en = (ms_cnt_r == 32'(CYC_PER_MS - 1));
  assign tenth_en = ms_en && (tenth_cnt_r == 8'(MS_PER_TENTH - 1));

  always_comb begin
    ms_cnt_nxt = ms_en ? 32'h00000000 : ms_cnt_r + 32'h00000001;
    tenth_cnt_nxt = tenth_cnt_r;
    if (ms_en) tenth_cnt_nxt = tenth_en ? 8'h00 : tenth_cnt_r + 8'h01;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ms_cnt_r <= 32'h00000000;
      tenth_cnt_r <= 8'h00;
    end else begin
      ms_cnt_r <= ms_cnt_nxt;
      tenth_cnt_r <= tenth_cnt_nxt;
    end
  end

  // ---------------------------------------------------------------
  // frame acceptance, policy and scaling
  // ---------------------------------------------------------------
  msc_pkg::msc_policy_t policy;
  logic is_bcast, is_own, accept, want_reply;
  logic hit_r, hit_nxt;
  logic coast_r, coast_nxt;
  logic fv_r, fv_nxt;
  logic [15:0] freq_r, freq_nxt;
  logic [25:0] scaled;

  assign policy = msc_pkg::msc_policy_t'(config_r[9:8]);
  assign is_bcast = (frm.addr == `MSC_BCAST_ADDR);
  assign is_own = !is_bcast && (frm.addr == station_r[7:0]);
  assign accept = frm.valid && (is_bcast || is_own);
  // product tops out near 2^26, so the quotient may exceed 16 bits
  assign scaled = (26'(frm.freq) * 26'(ratio_r)) / `MSC_RATIO_SCALE;

  always_comb begin
    want_reply = 1'b0;
    unique case (policy)
      msc_pkg::MSC_POL_OWN_ONLY: want_reply = accept && is_own;
      msc_pkg::MSC_POL_SILENT: want_reply = 1'b0;
      default: want_reply = accept;
    endcase
    hit_nxt = accept;
    coast_nxt = accept && frm.coast &&
                !(is_bcast && policy == msc_pkg::MSC_POL_NO_BC_COAST);
    fv_nxt = accept && frm.has_freq;
    freq_nxt = freq_r;
    if (fv_nxt) begin
      freq_nxt = (scaled > 26'h000ffff) ? 16'hffff : scaled[15:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hit_r <= 1'b0;
      coast_r <= 1'b0;
      fv_r <= 1'b0;
      freq_r <= 16'h0000;
    end else begin
      hit_r <= hit_nxt;
      coast_r <= coast_nxt;
      fv_r <= fv_nxt;
      freq_r <= freq_nxt;
    end
  end

  // ---------------------------------------------------------------
  // reception timeout watchdog
  // ---------------------------------------------------------------
  logic [15:0] tmo_cnt_r, tmo_cnt_nxt;
  logic fail_r, fail_nxt;

  always_comb begin
    tmo_cnt_nxt = tmo_cnt_r;
    fail_nxt = fail_r;
    if (timeout_r == 16'h0000) begin
      tmo_cnt_nxt = 16'h0000;
      fail_nxt = 1'b0;
    end else if (tenth_en && tmo_cnt_r < timeout_r) begin
      tmo_cnt_nxt = tmo_cnt_r + 16'h0001;
      if (tmo_cnt_r + 16'h0001 >= timeout_r) fail_nxt = 1'b1;
    end
    // a frame in the same cycle outranks the expiry
    if (accept || tmo_written) begin
      tmo_cnt_nxt = 16'h0000;
      fail_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tmo_cnt_r <= 16'h0000;
      fail_r <= 1'b0;
    end else begin
      tmo_cnt_r <= tmo_cnt_nxt;
      fail_r <= fail_nxt;
    end
  end

  // ---------------------------------------------------------------
  // reply turnaround
  // ---------------------------------------------------------------
  msc_pkg::msc_state_t state_r, state_nxt;
  logic [7:0] dly_cnt_r, dly_cnt_nxt;
  logic [31:0] proc_cnt_r, proc_cnt_nxt;
  logic go_r, go_nxt;
  logic busy_r, busy_nxt;
  logic dly_done, proc_done;

  // ms count is coarse: the first tick may land up to 1 ms early
  assign dly_done = (dly_cnt_r >= delay_r[7:0]);
  assign proc_done = (proc_cnt_r >= 32'(PROC_CYC));

  always_comb begin
    state_nxt = state_r;
    dly_cnt_nxt = dly_cnt_r;
    proc_cnt_nxt = proc_cnt_r;
    go_nxt = 1'b0;
    busy_nxt = busy_r;
    unique case (state_r)
      msc_pkg::MSC_ST_IDLE: begin
        if (want_reply) begin
          state_nxt = msc_pkg::MSC_ST_WAIT;
          dly_cnt_nxt = 8'h00;
          proc_cnt_nxt = 32'h00000000;
          busy_nxt = 1'b1;
        end
      end
      msc_pkg::MSC_ST_WAIT: begin
        if (ms_en && !dly_done) dly_cnt_nxt = dly_cnt_r + 8'h01;
        if (!proc_done) proc_cnt_nxt = proc_cnt_r + 32'h00000001;
        if (dly_done && proc_done) begin
          state_nxt = msc_pkg::MSC_ST_SEND;
          go_nxt = 1'b1;
        end
      end
      msc_pkg::MSC_ST_SEND: begin
        if (tx_done) begin
          state_nxt = msc_pkg::MSC_ST_IDLE;
          busy_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = msc_pkg::MSC_ST_IDLE;
        busy_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= msc_pkg::MSC_ST_IDLE;
      dly_cnt_r <= 8'h00;
      proc_cnt_r <= 32'h00000000;
      go_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      dly_cnt_r <= dly_cnt_nxt;
      proc_cnt_r <= proc_cnt_nxt;
      go_r <= go_nxt;
      busy_r <= busy_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  logic [1:0] baud_r, par_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      baud_r <= 2'h0;
      par_r <= 2'h0;
    end else begin
      baud_r <= config_r[1:0];
      par_r <= config_r[5:4];
    end
  end

  assign par_rdata = rdata_r;
  assign par_ack = ack_r;
  assign par_err = err_r;
  assign bit_tick = tick_r;
  assign baud_sel = baud_r;
  assign parity_sel = par_r;
  assign frame_hit = hit_r;
  assign reply_go = go_r;
  assign reply_busy = busy_r;
  assign coast_cmd = coast_r;
  assign freq_valid = fv_r;
  assign freq_out = freq_r;
  assign comm_fail = fail_r;

endmodule : msc_comm

// [msc_consts.svh]
// offsets, field positions, reset values and timing counts for the comm block
`ifndef MSC_CONSTS_SVH
`define MSC_CONSTS_SVH

// ---------------------------------------------------------------
// parameter indices (low part of the group function code)
// ---------------------------------------------------------------
`define MSC_IDX_STATION 8'h00
`define MSC_IDX_CONFIG 8'h01
`define MSC_IDX_TIMEOUT 8'h02
`define MSC_IDX_DELAY 8'h03
`define MSC_IDX_RATIO 8'h04
`define MSC_IDX_SPARE 8'h05

// ---------------------------------------------------------------
// reset values and ranges
// ---------------------------------------------------------------
`define MSC_RST_STATION 16'h0001
`define MSC_RST_CONFIG 16'h0000
`define MSC_RST_TIMEOUT 16'h0064
`define MSC_RST_DELAY 16'h0005
`define MSC_RST_RATIO 16'h0064
`define MSC_MAX_STATION 16'h00f7
`define MSC_MAX_TIMEOUT 16'h03e8
`define MSC_MAX_DELAY 16'h00c8
`define MSC_MIN_RATIO 16'h0001
`define MSC_MAX_RATIO 16'h03e8
`define MSC_RATIO_SCALE 26'h0000064
`define MSC_BCAST_ADDR 8'h00

// ---------------------------------------------------------------
// config digit fields and codes
// ---------------------------------------------------------------
`define MSC_CFG_BAUD 3:0
`define MSC_CFG_PAR 7:4
`define MSC_CFG_POL 11:8
`define MSC_CFG_RSV 15:12
`define MSC_MAX_BAUD 4'h2
`define MSC_MAX_PAR 4'h2
`define MSC_MAX_POL 4'h3

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define MSC_CLK_HZ 50000000
`define MSC_BIT_CYC_9600 (`MSC_CLK_HZ / 9600)
`define MSC_BIT_CYC_19200 (`MSC_CLK_HZ / 19200)
`define MSC_BIT_CYC_38400 (`MSC_CLK_HZ / 38400)
`define MSC_MS_PER_TENTH 100
`define MSC_CYC_PER_MS (`MSC_CLK_HZ / 1000)

`endif

// [msc_pkg.sv]
// types shared by the serial comm configuration block
package msc_pkg;

  typedef enum logic [1:0] {
    MSC_POL_NORMAL = 2'h0,
    MSC_POL_OWN_ONLY = 2'h1,
    MSC_POL_SILENT = 2'h2,
    MSC_POL_NO_BC_COAST = 2'h3
  } msc_policy_t;

  typedef enum logic [2:0] {
    MSC_ST_IDLE = 3'b001,
    MSC_ST_WAIT = 3'b010,
    MSC_ST_SEND = 3'b100
  } msc_state_t;

  // one decoded request frame from the receive path
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic coast;
    logic has_freq;
    logic [15:0] freq;
  } msc_frame_t;

endpackage : msc_pkg

// [msc_comm_assertions.sv]
// concurrent checks on the comm configuration block ports
`timescale 1ns/1ps
module msc_comm_assertions (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic par_wr,
  input wire logic par_rd,
  input wire logic [7:0] par_idx,
  input wire logic [15:0] par_wdata,
  input wire logic par_ack,
  input wire logic par_err,
  input msc_pkg::msc_frame_t frm,
  input wire logic [1:0] baud_sel,
  input wire logic [1:0] parity_sel,
  input wire logic frame_hit,
  input wire logic reply_go,
  input wire logic reply_busy,
  input wire logic coast_cmd
);
  // ---------------------------------------------------------------
  // shadow of stored station and config
  // ---------------------------------------------------------------
  logic wr_q;
  logic [7:0] idx_q;
  logic [15:0] dat_q;
  logic [15:0] stn_r;
  logic [15:0] cfg_r;
  logic hit;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_q <= 1'b0;
      stn_r <= 16'h0001;
      cfg_r <= 16'h0000;
    end else begin
      wr_q <= par_wr;
      idx_q <= par_idx;
      dat_q <= par_wdata;
      if (wr_q && par_ack && !par_err && idx_q == 8'h00) stn_r <= dat_q;
      if (wr_q && par_ack && !par_err && idx_q == 8'h01) cfg_r <= dat_q;
    end
  end
  assign hit = frm.valid && (frm.addr == 8'h00 || frm.addr == stn_r[7:0]);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_ack;
    (par_wr || par_rd) |=> par_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_st_range;
    par_wr && par_idx == 8'h00 && par_wdata > 16'h00f7 |=> par_err;
  endproperty
  a_st_range: assert property (p_st_range) else $error("bad station");
  property p_hit;
    hit |=> frame_hit;
  endproperty
  a_hit: assert property (p_hit) else $error("frame missed");
  property p_drop;
    frm.valid && !hit |=> !frame_hit;
  endproperty
  a_drop: assert property (p_drop) else $error("foreign frame");
  property p_coast;
    hit && frm.coast && frm.addr == 8'h00 && cfg_r[11:8] == 4'h3 |=> !coast_cmd;
  endproperty
  a_coast: assert property (p_coast) else $error("coast obeyed");
  property p_silent;
    hit && !reply_busy && cfg_r[11:8] == 4'h2 |=> !reply_busy;
  endproperty
  a_silent: assert property (p_silent) else $error("reply started");
  property p_proc;
    $rose(reply_busy) |-> !reply_go [*8];
  endproperty
  a_proc: assert property (p_proc) else $error("reply too soon");
  property p_baud;
    $changed(baud_sel) |-> $past(par_wr, 1) || $past(par_wr, 2);
  endproperty
  a_baud: assert property (p_baud) else $error("rate moved");
  property p_par;
    $changed(parity_sel) |-> $past(par_wr, 1) || $past(par_wr, 2);
  endproperty
  a_par: assert property (p_par) else $error("parity moved");
endmodule : msc_comm_assertions

bind msc_comm msc_comm_assertions i_msc_comm_assertions (.*);

// [msc_host_model.sv]
// host side model that finishes each reply transmission
`timescale 1ns/1ps
module msc_host_model #(
  parameter int TX_CYC = 5
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reply_go,
  output logic tx_done
);
  int cnt;
  // done only ever follows a reply start
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt <= 0;
      tx_done <= 1'b0;
    end else begin
      if (reply_go) cnt <= TX_CYC;
      else if (cnt > 0) cnt <= cnt - 1;
      tx_done <= (cnt == 1);
    end
  end
endmodule : msc_host_model

// [modbus_slave_comm_config_tb.sv]
// testbench for the comm configuration block
`timescale 1ns/1ps
module modbus_slave_comm_config_tb;
  logic ref_clk = 0;
  logic rst = 1;
  logic par_wr = 0;
  logic par_rd = 0;
  logic [7:0] par_idx = 0;
  logic [15:0] par_wdata = 0;
  msc_pkg::msc_frame_t frm = '0;
  logic tx_done, bit_tick, frame_hit, reply_go, reply_busy, coast_cmd;
  logic par_ack, par_err, freq_valid, comm_fail;
  logic [1:0] baud_sel, parity_sel;
  logic [15:0] par_rdata, freq_out;
  int failures = 0;
  int checked = 0;
  msc_comm #(.CYC_PER_MS(10), .MS_PER_TENTH(4), .PROC_CYC(20)) i_msc_comm (
    .ref_clk(ref_clk), .rst(rst), .par_wr(par_wr), .par_rd(par_rd),
    .par_idx(par_idx), .par_wdata(par_wdata), .par_rdata(par_rdata),
    .par_ack(par_ack), .par_err(par_err), .frm(frm), .tx_done(tx_done),
    .bit_tick(bit_tick), .baud_sel(baud_sel), .parity_sel(parity_sel),
    .frame_hit(frame_hit), .reply_go(reply_go), .reply_busy(reply_busy),
    .coast_cmd(coast_cmd), .freq_valid(freq_valid), .freq_out(freq_out),
    .comm_fail(comm_fail));
  msc_host_model i_msc_host_model (.ref_clk(ref_clk), .rst(rst),
    .reply_go(reply_go), .tx_done(tx_done));
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // read compares rdata against d
  task automatic acc(input logic wr, input logic [7:0] i,
    input logic [15:0] d, input logic e);
    @(posedge ref_clk);
    par_wr <= wr;
    par_rd <= !wr;
    par_idx <= i;
    par_wdata <= d;
    @(posedge ref_clk);
    par_wr <= 1'b0;
    par_rd <= 1'b0;
    #1;
    chk({par_ack, par_err}, {1'b1, e});
    if (!wr) chk(par_rdata, d);
  endtask : acc
  task automatic fr(input logic [7:0] a, input logic c, input logic [15:0] f,
    input logic h);
    @(posedge ref_clk);
    frm <= '{1'b1, a, c, 1'b1, f};
    @(posedge ref_clk);
    frm.valid <= 1'b0;
    #1;
    chk({frame_hit, freq_valid}, {h, h});
  endtask : fr
  // cycles between two full bit ticks; the first gap after a rate change
  // may be short because the divider is not restarted
  task automatic gap(output int g);
    repeat (3) begin
      g = 0;
      do begin
        @(posedge ref_clk);
        #1;
        g++;
      end while (bit_tick !== 1'b1 && g < 6000);
    end
  endtask : gap
  // cycles until reply start, then wait out the transmission
  task automatic settle(output int n);
    n = 0;
    while (reply_go !== 1'b1 && n < 300) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    repeat (20) @(posedge ref_clk);
  endtask : settle
  task automatic wrap_up;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  localparam logic [15:0] RV [6] = '{16'h1, 16'h0, 16'h64, 16'h5, 16'h64, 16'h0};
  localparam logic [3:0] BE = 4'b1001;
  localparam logic [3:0] CE = 4'b0111;
  initial begin
    int n;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) acc(0, i, RV[i], 0);
    acc(0, 8'h06, 16'h0, 1);
    acc(1, 8'h00, 16'h00f7, 0);
    acc(1, 8'h00, 16'h00f8, 1);
    acc(0, 8'h00, 16'h00f7, 0);
    for (int k = 0; k < 3; k++) begin
      acc(1, 8'h01, {8'h00, k[3:0], k[3:0]}, 0);
      @(posedge ref_clk);
      #1;
      chk({baud_sel, parity_sel}, {k[1:0], k[1:0]});
    end
    gap(n);
    chk(n, 16'h0516);
    acc(1, 8'h01, 16'h0030, 1);
    acc(1, 8'h01, 16'h0400, 1);
    acc(1, 8'h01, 16'h1000, 1);
    acc(1, 8'h01, 16'h0000, 0);
    fr(8'hf7, 0, 16'd1000, 1);
    chk(freq_out, 16'd1000);
    settle(n);
    chk(n >= 38 && n <= 55, 1);
    acc(1, 8'h04, 16'd250, 0);
    fr(8'h00, 0, 16'd1000, 1);
    chk({freq_out, reply_busy}, {16'd2500, 1'b1});
    settle(n);
    acc(1, 8'h04, 16'd1000, 0);
    acc(1, 8'h04, 16'd0, 1);
    acc(1, 8'h03, 16'd0, 0);
    acc(1, 8'h03, 16'd201, 1);
    fr(8'hf7, 0, 16'hffff, 1);
    chk(freq_out, 16'hffff);
    settle(n);
    chk(n >= 18 && n <= 24, 1);
    fr(8'h05, 0, 16'h0, 0);
    chk(reply_busy, 0);
    for (int p = 0; p < 4; p++) begin
      acc(1, 8'h01, {4'h0, p[3:0], 8'h00}, 0);
      fr(8'h00, 1, 16'h0, 1);
      chk({coast_cmd, reply_busy}, {CE[p], BE[p]});
      settle(n);
    end
    acc(1, 8'h01, 16'h0200, 0);
    fr(8'hf7, 0, 16'h0, 1);
    chk(reply_busy, 0);
    acc(1, 8'h02, 16'd1001, 1);
    acc(1, 8'h02, 16'd2, 0);
    repeat (100) @(posedge ref_clk);
    #1;
    chk(comm_fail, 1);
    fr(8'hf7, 0, 16'h0, 1);
    chk(comm_fail, 0);
    acc(1, 8'h02, 16'd0, 0);
    repeat (300) @(posedge ref_clk);
    #1;
    chk(comm_fail, 0);
    wrap_up();
  end
  // hang guard well beyond the expected run
  initial begin
    #400000;
    failures++;
    wrap_up();
  end
endmodule : modbus_slave_comm_config_tb
